// ===== rtl/css_compare_skip.sv
`timescale 1ns/10ps
`default_nettype none
`include "css_map.svh"
module css_compare_skip
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Fetched instruction word, offered at the first quarter of each cycle.
  input wire logic [15:0] INSTR_WORD,
  input wire logic INSTR_TWO_WORD,
  // Core state.
  input wire logic [7:0] WORKING_REGISTER,
  input wire logic [3:0] BANK_SELECT_REGISTER,
  input wire logic EXT_SET_EN,
  input wire css_pkg::css_addr_t INDEX_BASE,
  // Data memory load port.
  input wire logic MEM_WE,
  input wire css_pkg::css_addr_t MEM_WADDR,
  input wire logic [7:0] MEM_WDATA,
  // Results.
  output logic [3:0] Q_PHASE,
  output css_pkg::css_addr_t OPERAND_ADDR,
  output logic [7:0] OPERAND_DATA,
  output logic SKIP_TAKEN,
  output logic FLUSH_PREFETCH,
  output logic NOP_CYCLE,
  output logic WRITE_BACK_EN,
  output logic STATUS_WE
);
  import css_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic css_addr_t css_operand_addr(input logic [7:0] f, input logic a,
    input logic ext, input logic [3:0] bank_select_register, input css_addr_t idx);
    css_addr_t r;
    if (!a && ext && f <= `CSS_LIT_MAX)
      r = idx + {4'h0, f};
    else if (!a)
      r = {(f < `CSS_ACC_SPLIT) ? `CSS_ACC_LO_BANK : `CSS_ACC_HI_BANK, f};
    else
      r = {bank_select_register, f};
    return r;
  endfunction : css_operand_addr

  // Bit 8 of the result is the borrow of an unsigned subtraction.
  function automatic logic [8:0] css_sub(input logic [7:0] x, input logic [7:0] y);
    return {1'b0, x} - {1'b0, y};
  endfunction : css_sub

  // ==========================================================
  // Quarter-cycle ring
  // ==========================================================
  css_phase_e phase_q;
  css_state_e state_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
      phase_q <= CSS_Q1;
    else
      unique case (phase_q)
        CSS_Q1: phase_q <= CSS_Q2;
        CSS_Q2: phase_q <= CSS_Q3;
        CSS_Q3: phase_q <= CSS_Q4;
        CSS_Q4: phase_q <= CSS_Q1;
      endcase
  end
  assign Q_PHASE = phase_q;

  // ==========================================================
  // Decode (first quarter)
  // ==========================================================
  logic [15:0] instr_q;
  logic [7:0] w_q;
  logic [3:0] bsr_q;
  logic ext_q;
  css_addr_t idx_q;
  logic op_gt_q, op_lt_q, two_q;
  logic exec_q1, exec_q2, exec_q3;

  assign exec_q1 = (state_q == CSS_EXEC) && (phase_q == CSS_Q1);
  assign exec_q2 = (state_q == CSS_EXEC) && (phase_q == CSS_Q2);
  assign exec_q3 = (state_q == CSS_EXEC) && (phase_q == CSS_Q3);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      instr_q <= `CSS_RST_WORD;
      op_gt_q <= 1'b0;
      op_lt_q <= 1'b0;
      w_q <= `CSS_RST_BYTE;
      bsr_q <= 4'h0;
      ext_q <= 1'b0;
      idx_q <= `CSS_RST_ADDR;
    end
    else if (exec_q1)
    begin
      instr_q <= INSTR_WORD;
      op_gt_q <= INSTR_WORD[`CSS_OP_MSB:`CSS_OP_LSB] == `CSS_OP_GT;
      op_lt_q <= INSTR_WORD[`CSS_OP_MSB:`CSS_OP_LSB] == `CSS_OP_LT;
      w_q <= WORKING_REGISTER;
      bsr_q <= BANK_SELECT_REGISTER;
      ext_q <= EXT_SET_EN;
      idx_q <= INDEX_BASE;
    end
  end

  // ==========================================================
  // Operand read (second quarter)
  // ==========================================================
  css_addr_t addr_d;
  logic [7:0] rdata;

  assign addr_d = css_operand_addr(instr_q[7:0], instr_q[`CSS_A_BIT], ext_q, bsr_q, idx_q);

  always_ff @(posedge CLK)
  begin
    if (RST)
      OPERAND_ADDR <= `CSS_RST_ADDR;
    else if (exec_q2)
      OPERAND_ADDR <= addr_d;
  end

  css_dmem u_dmem
  (
    .clk(CLK),
    .we(MEM_WE),
    .waddr(MEM_WADDR),
    .wdata(MEM_WDATA),
    .re(exec_q2),
    .raddr(addr_d),
    .rdata(rdata)
  );

  // ==========================================================
  // Process (third quarter)
  // ==========================================================
  logic [8:0] diff;
  logic skip_d;

  assign diff = css_sub(rdata, w_q);
  assign skip_d = (op_gt_q && !diff[8] && (diff[7:0] != 8'h00)) || (op_lt_q && diff[8]);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      OPERAND_DATA <= `CSS_RST_BYTE;
      SKIP_TAKEN <= 1'b0;
      FLUSH_PREFETCH <= 1'b0;
    end
    else
    begin
      FLUSH_PREFETCH <= exec_q3 && skip_d;
      if (exec_q3)
      begin
        OPERAND_DATA <= rdata;
        SKIP_TAKEN <= skip_d;
      end
    end
  end

  // ==========================================================
  // Sequencing of inserted empty cycles
  // ==========================================================
  // The discarded word's length is sampled when it sits on the fetch
  // port, in the first quarter of the first empty cycle.
  always_ff @(posedge CLK)
  begin
    if (RST)
      two_q <= 1'b0;
    else if (state_q == CSS_SKIP1 && phase_q == CSS_Q1)
      two_q <= INSTR_TWO_WORD;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= CSS_EXEC;
      NOP_CYCLE <= 1'b0;
    end
    else if (phase_q == CSS_Q4)
      unique case (state_q)
        CSS_EXEC:
        begin
          state_q <= SKIP_TAKEN ? CSS_SKIP1 : CSS_EXEC;
          NOP_CYCLE <= SKIP_TAKEN;
        end
        CSS_SKIP1:
        begin
          state_q <= two_q ? CSS_SKIP2 : CSS_EXEC;
          NOP_CYCLE <= two_q;
        end
        CSS_SKIP2:
        begin
          state_q <= CSS_EXEC;
          NOP_CYCLE <= 1'b0;
        end
        default:
        begin
          state_q <= CSS_EXEC;
          NOP_CYCLE <= 1'b0;
        end
      endcase
  end

  always_ff @(posedge CLK)
  begin
    WRITE_BACK_EN <= 1'b0;
    STATUS_WE <= 1'b0;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_unsigned;
    FLUSH_PREFETCH |-> (op_gt_q && OPERAND_DATA > w_q) || (op_lt_q && OPERAND_DATA < w_q);
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("skip without unsigned cause");

  property p_gt;
    (state_q == CSS_EXEC && phase_q == CSS_Q4 && op_gt_q) |-> SKIP_TAKEN == (OPERAND_DATA > w_q);
  endproperty
  a_gt: assert property (p_gt) else $error("greater skip wrong");

  property p_lt;
    (state_q == CSS_EXEC && phase_q == CSS_Q4 && op_lt_q) |-> SKIP_TAKEN == (OPERAND_DATA < w_q);
  endproperty
  a_lt: assert property (p_lt) else $error("less skip wrong");

  property p_one_nop;
    FLUSH_PREFETCH |=> NOP_CYCLE [*4];
  endproperty
  a_one_nop: assert property (p_one_nop) else $error("skip cycle missing");

  property p_two_nop;
    (state_q == CSS_SKIP1 && phase_q == CSS_Q4) |=> (NOP_CYCLE == two_q) [*4];
  endproperty
  a_two_nop: assert property (p_two_nop) else $error("two-word skip length wrong");

  property p_access;
    (exec_q2 && !instr_q[8] && !(ext_q && instr_q[7:0] <= 8'h5F)) |=>
      OPERAND_ADDR == {(instr_q[7:0] < 8'h60) ? 4'h0 : 4'hF, instr_q[7:0]};
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_banked;
    (exec_q2 && instr_q[8]) |=> OPERAND_ADDR == {bsr_q, instr_q[7:0]};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    (exec_q2 && !instr_q[8] && ext_q && instr_q[7:0] <= 8'h5F) |=>
      OPERAND_ADDR == idx_q + {4'h0, instr_q[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_quarters;
    (Q_PHASE == CSS_Q1) |=> (Q_PHASE == CSS_Q2) ##1 (Q_PHASE == CSS_Q3) ##1 (Q_PHASE == CSS_Q4)
      ##1 (Q_PHASE == CSS_Q1);
  endproperty
  a_quarters: assert property (p_quarters) else $error("quarter order wrong");

  property p_no_wb;
    !WRITE_BACK_EN && !(NOP_CYCLE && FLUSH_PREFETCH);
  endproperty
  a_no_wb: assert property (p_no_wb) else $error("write-back or flush in empty cycle");

  property p_no_status;
    !STATUS_WE;
  endproperty
  a_no_status: assert property (p_no_status) else $error("status written");

  c_gt_skip: cover property (FLUSH_PREFETCH && op_gt_q);
  c_lt_skip: cover property (FLUSH_PREFETCH && op_lt_q);
  c_two_word: cover property (state_q == CSS_SKIP2);
  c_no_skip: cover property (phase_q == CSS_Q4 && op_gt_q && !SKIP_TAKEN);
endmodule : css_compare_skip
`default_nettype wire

// ===== rtl/css_map.svh
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

// Upper seven opcode bits of the two compare-and-skip instructions.
`define CSS_OP_GT 7'h32
`define CSS_OP_LT 7'h30
// Access-bank split point and its two banks.
`define CSS_ACC_SPLIT 8'h60
`define CSS_ACC_LO_BANK 4'h0
`define CSS_ACC_HI_BANK 4'hF
// Largest operand that uses indexed literal offset addressing.
`define CSS_LIT_MAX 8'h5F
// Instruction field positions.
`define CSS_OP_MSB 15
`define CSS_OP_LSB 9
`define CSS_A_BIT 8
// Reset values.
`define CSS_RST_BYTE 8'h00
`define CSS_RST_ADDR 12'h000
`define CSS_RST_WORD 16'h0000

`endif

// ===== rtl/css_pkg.sv
package css_pkg;
  typedef enum logic [3:0]
  {
    CSS_Q1 = 4'b0001,
    CSS_Q2 = 4'b0010,
    CSS_Q3 = 4'b0100,
    CSS_Q4 = 4'b1000
  } css_phase_e;

  typedef enum logic [2:0]
  {
    CSS_EXEC = 3'b001,
    CSS_SKIP1 = 3'b010,
    CSS_SKIP2 = 3'b100
  } css_state_e;

  typedef logic [11:0] css_addr_t;
endpackage : css_pkg

// ===== rtl/css_dmem.sv
`timescale 1ns/10ps
`default_nettype none
module css_dmem
(
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic we,
  input wire css_pkg::css_addr_t waddr,
  input wire logic [7:0] wdata,
  // Read port.
  input wire logic re,
  input wire css_pkg::css_addr_t raddr,
  output logic [7:0] rdata
);
  import css_pkg::*;

  logic [7:0] mem [0:4095];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : css_dmem
`default_nettype wire

// ===== verif/test_compare_skip_instr_exec.sv
`timescale 1ns/10ps
`default_nettype none
module test_compare_skip_instr_exec;
  import css_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
    logic ext;
    logic two;
    logic skip;
  } css_row_s;
  // ========================================
  // Stimulus and design
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [15:0] INSTR_WORD = 16'h0000;
  logic INSTR_TWO_WORD = 1'b0;
  logic [7:0] WORKING_REGISTER = 8'h00;
  logic [3:0] BANK_SELECT_REGISTER = 4'h0;
  logic EXT_SET_EN = 1'b0;
  css_addr_t INDEX_BASE = 12'h200;
  logic MEM_WE = 1'b0;
  css_addr_t MEM_WADDR = 12'h000;
  logic [7:0] MEM_WDATA = 8'h00;
  logic [3:0] Q_PHASE;
  css_addr_t OPERAND_ADDR;
  logic [7:0] OPERAND_DATA;
  logic SKIP_TAKEN, FLUSH_PREFETCH, NOP_CYCLE, WRITE_BACK_EN, STATUS_WE;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] shadow [0:4095];
  css_row_s rows [0:9];

  always #5 CLK = ~CLK;

  css_compare_skip css_compare_skip_i (.CLK(CLK), .RST(RST), .INSTR_WORD(INSTR_WORD),
    .INSTR_TWO_WORD(INSTR_TWO_WORD), .WORKING_REGISTER(WORKING_REGISTER),
    .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .EXT_SET_EN(EXT_SET_EN),
    .INDEX_BASE(INDEX_BASE), .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR), .MEM_WDATA(MEM_WDATA),
    .Q_PHASE(Q_PHASE), .OPERAND_ADDR(OPERAND_ADDR), .OPERAND_DATA(OPERAND_DATA),
    .SKIP_TAKEN(SKIP_TAKEN), .FLUSH_PREFETCH(FLUSH_PREFETCH), .NOP_CYCLE(NOP_CYCLE),
    .WRITE_BACK_EN(WRITE_BACK_EN), .STATUS_WE(STATUS_WE));

  // ========================================
  // Expectations and checks
  function automatic css_addr_t exp_addr(input css_row_s r);
    if (r.word[8])
      return {r.bank_select_register, r.word[7:0]};
    if (r.ext && r.word[7:0] <= 8'h5F)
      return INDEX_BASE + {4'h0, r.word[7:0]};
    return {(r.word[7:0] < 8'h60) ? 4'h0 : 4'hF, r.word[7:0]};
  endfunction : exp_addr

  function automatic logic is_cmp(input css_row_s r);
    return r.word[15:9] == 7'b0110010 || r.word[15:9] == 7'b0110000;
  endfunction : is_cmp

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // The strobe stays high between back-to-back loads; the caller drops it.
  task automatic mem_load(input css_addr_t a, input logic [7:0] d);
    MEM_WE = 1'b1;
    MEM_WADDR = a;
    MEM_WDATA = d;
    shadow[a] = d;
    @(negedge CLK);
  endtask : mem_load

  // Bounded wait for the first quarter of a normal cycle, then offer the row.
  task automatic start(input css_row_s r);
    int n;
    n = 0;
    while (!(Q_PHASE === 4'b0001 && NOP_CYCLE === 1'b0))
    begin
      @(negedge CLK);
      n++;
      if (n > 40)
      begin
        chk("q1_wait", 1, 0);
        end_of_test();
      end
    end
    INSTR_WORD = r.word;
    WORKING_REGISTER = r.working_register;
    BANK_SELECT_REGISTER = r.bank_select_register;
    EXT_SET_EN = r.ext;
    INSTR_TWO_WORD = r.two;
  endtask : start

  task automatic run_row(input css_row_s r);
    css_addr_t a;
    logic s;
    int n;
    a = exp_addr(r);
    s = r.skip;
    n = 0;
    start(r);
    repeat (2) @(negedge CLK);
    chk("phase_q3", 4'b0100, Q_PHASE);
    if (is_cmp(r))
      chk("addr", a, OPERAND_ADDR);
    @(negedge CLK);
    if (is_cmp(r))
      chk("data", shadow[a], OPERAND_DATA);
    chk("skip", s, SKIP_TAKEN);
    chk("flush", s, FLUSH_PREFETCH);
    // A compare offered in the empty cycle must not disturb the result.
    // It stands until the empty cycle's first quarter has ended.
    INSTR_WORD = s ? 16'h6500 : 16'h0000;
    repeat (10)
    begin
      chk("wb_status", 0, {WRITE_BACK_EN, STATUS_WE});
      @(negedge CLK);
      if (Q_PHASE === 4'b0010)
        INSTR_WORD = 16'h0000;
      if (NOP_CYCLE === 1'b1)
      begin
        n++;
        chk("addr_hold", a, OPERAND_ADDR);
      end
    end
    chk("nop_clocks", s ? (r.two ? 8 : 4) : 0, n);
    INSTR_TWO_WORD = 1'b0;
  endtask : run_row

  task automatic reset_chk();
    chk("phase_rst", 4'b0001, Q_PHASE);
    chk("outs_rst", 0, {OPERAND_ADDR, OPERAND_DATA, SKIP_TAKEN, FLUSH_PREFETCH,
      NOP_CYCLE, WRITE_BACK_EN, STATUS_WE});
  endtask : reset_chk

  // ========================================
  // Sequence
  initial
  begin
    rows = '{'{16'h6540, 8'h7F, 4'h3, 1'b0, 1'b0, 1'b1},
      '{16'h6540, 8'h80, 4'h3, 1'b0, 1'b0, 1'b0},
      '{16'h6140, 8'h81, 4'h3, 1'b0, 1'b1, 1'b1},
      '{16'h6140, 8'h80, 4'h3, 1'b0, 1'b0, 1'b0},
      '{16'h6480, 8'h10, 4'h3, 1'b0, 1'b1, 1'b1},
      '{16'h605F, 8'h02, 4'h3, 1'b1, 1'b0, 1'b1},
      '{16'h6060, 8'h02, 4'h3, 1'b1, 1'b0, 1'b0},
      '{16'h6510, 8'h00, 4'h5, 1'b1, 1'b0, 1'b1},
      '{16'h605F, 8'hA0, 4'h3, 1'b0, 1'b0, 1'b1},
      '{16'h6610, 8'h00, 4'h3, 1'b0, 1'b0, 1'b0}};
    @(negedge CLK);
    mem_load(12'h340, 8'h80);
    mem_load(12'hF80, 8'hF0);
    mem_load(12'h25F, 8'h01);
    mem_load(12'hF60, 8'h02);
    mem_load(12'h510, 8'h33);
    mem_load(12'h05F, 8'h90);
    MEM_WE = 1'b0;
    repeat (3) @(negedge CLK);
    reset_chk();
    RST = 1'b0;
    for (int i = 0; i < 10; i++)
      run_row(rows[i]);
    // Reset landing inside an empty cycle must abandon the skip.
    start(rows[0]);
    repeat (5) @(negedge CLK);
    RST = 1'b1;
    repeat (2) @(negedge CLK);
    reset_chk();
    RST = 1'b0;
    run_row(rows[2]);
    end_of_test();
  end
endmodule : test_compare_skip_instr_exec
`default_nettype wire
